// [pgt_cfg.svh]
// constants for the pulse generation and capture timer channel
`ifndef PGT_CFG_SVH
`define PGT_CFG_SVH
`define PGT_ADDR_ENABLE      12'h000
`define PGT_ADDR_RUN         12'h004
`define PGT_ADDR_CONTROL     12'h008
`define PGT_ADDR_MODE        12'h00C
`define PGT_ADDR_TOGGLE      12'h010
`define PGT_ADDR_STATUS      12'h014
`define PGT_ADDR_MASK        12'h018
`define PGT_ADDR_CMP_FIRST   12'h01C
`define PGT_ADDR_CMP_SECOND  12'h020
`define PGT_ADDR_CAP_FIRST   12'h024
`define PGT_ADDR_CAP_SECOND  12'h028
`define PGT_ADDR_COUNTER     12'h02C
`define PGT_CTL_DBUF_BIT     0
`define PGT_CTL_COUNT_START_SELECT_BIT    1
`define PGT_CTL_TRGEDGE_BIT  2
`define PGT_MOD_CLK_LSB      0
`define PGT_MOD_CLE_BIT      3
`define PGT_MOD_CPM_LSB      4
`define PGT_MOD_SWCAP_BIT    7
`define PGT_TGL_EN_LSB       0
`define PGT_TGL_CTL_LSB      4
`define PGT_TGL_INVERT       2'h0
`define PGT_TGL_SET          2'h1
`define PGT_TGL_CLEAR        2'h2
`define PGT_CLK_PIN          3'h0
`define PGT_CPM_OFF          3'h0
`define PGT_CPM_PIN          3'h2
`define PGT_CPM_PEER         3'h3
`define PGT_RUN_GO           2'h3
`define PGT_RST_MASK         3'h7
`define PGT_RST_MODE         8'h80
`endif

// [pgt_pkg.sv]
// types for the pulse generation and capture timer channel
package pgt_pkg;
	typedef enum logic [1:0] {PGT_STOPPED, PGT_ARMED, PGT_COUNTING} pgt_run_t;
endpackage

// [pgt_prescaler.sv]
// prescaler producing one-cycle ticks at divided rates
`timescale 1ns/1ps
`include "pgt_cfg.svh"
module pgt_prescaler
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	output logic            tick
);
	logic [6:0] div_r;
	logic [6:0] div_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic [7:0] ext;

	always_comb
	begin
		// select n ticks when the low n-1 divider bits are all ones: clk / 2^(n-1)
		ext      = (8'h01 << (sel - 3'h1)) - 8'h01;
		div_nxt  = run ? 7'(div_r + 7'h01) : 7'h00;
		tick_nxt = run && (sel != `PGT_CLK_PIN) && (({1'b0, div_r} & ext) == ext);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_r  <= 7'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule // pgt_prescaler

// [pgt_timer.sv]
// 16-bit timer channel with pulse output, double-buffered compares and capture
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pgt_cfg.svh"
// Overview of operation
// - toggle flop inverts on first and on second compare match when enabled
// - with double buffering, buffers load into compares on second match
// - toggle flop level drives the timer output pin
// - control code 10 forces the toggle flop low
// - four enable bits pick which events invert the toggle flop
// - clear enable 0 lets counter run free, 1 clears on period
// - clock select 000 counts input pin rises, others use prescaler
// - capture mode 000 disables hardware capture
// - mode 010 captures pin rise into first, fall into second
// - mode 011 captures peer toggle flop rise and fall edges
// - each capture raises the matching capture interrupt
// - run 11 starts prescaler and counter, 00 stops both
// - count start select 1, edge 0 arms trigger start on rise
// - armed counter waits idle for input rise, then counts
// - one-shot: first match sets flop high, second sets it low
// - match interrupt raised on second compare match
// - mask bits for overflow, second match, first match; 1 masks
// - toggle control 00 inverts, 01 sets, 10 clears
// - while stopped, compare writes go straight to active compares
// - writing 0 to software capture bit captures into first
module pgt_timer
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timerInputPin,
	input  wire logic        peerToggleFlop,
	output logic             timerOutputPin,
	output logic             matchInterrupt,
	output logic             captureFirstInterrupt,
	output logic             captureSecondInterrupt
);
	logic        enable_r, enable_nxt;
	logic [1:0]  run_r, run_nxt;
	logic [2:0]  control_r, control_nxt;
	logic [7:0]  mode_r, mode_nxt;
	logic [3:0]  toggleEn_r, toggleEn_nxt;
	logic [2:0]  mask_r, mask_nxt;
	logic [2:0]  status_r, status_nxt;
	logic [15:0] cmpFirst_r, cmpFirst_nxt, cmpSecond_r, cmpSecond_nxt;
	logic [15:0] bufFirst_r, bufFirst_nxt, bufSecond_r, bufSecond_nxt;
	logic [15:0] capFirst_r, capFirst_nxt, capSecond_r, capSecond_nxt;
	logic [15:0] counter_r, counter_nxt;
	logic        toggleFlop_r, toggleFlop_nxt;
	logic        pinPrev_r, peerPrev_r;
	logic        matchInt_r, matchInt_nxt, capFirstInt_r, capFirstInt_nxt;
	logic        capSecondInt_r, capSecondInt_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	pgt_pkg::pgt_run_t state_r, state_nxt;
	logic        preTick, wrEn, rdEn, mapped, counting, countTick;
	logic        pinRise, pinFall, peerRise, peerFall;
	logic        matchFirst, matchSecond, capEvFirst, capEvSecond, swCap, overflow;
	logic [2:0]  clkSel, capMode;

	pgt_prescaler u_prescaler
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (state_r != pgt_pkg::PGT_STOPPED),
		.sel     (clkSel),
		.tick    (preTick)
	);

	always_comb
	begin
		clkSel  = mode_r[`PGT_MOD_CLK_LSB +: 3];
		capMode = mode_r[`PGT_MOD_CPM_LSB +: 3];
		// a write lands on the edge at which pready is seen high, as the bus defines
		wrEn    = psel && penable && pwrite && pready_r;
		rdEn    = psel && penable && !pwrite && !pready_r;
		mapped  = (paddr[1:0] == 2'h0) && (paddr <= `PGT_ADDR_COUNTER);
		pinRise  = timerInputPin && !pinPrev_r;
		pinFall  = !timerInputPin && pinPrev_r;
		peerRise = peerToggleFlop && !peerPrev_r;
		peerFall = !peerToggleFlop && peerPrev_r;
		counting = enable_r && (state_r == pgt_pkg::PGT_COUNTING);
		countTick = counting && ((clkSel == `PGT_CLK_PIN) ? pinRise : preTick);
		matchFirst  = countTick && (counter_r == cmpFirst_r);
		matchSecond = countTick && (counter_r == cmpSecond_r);
		overflow    = countTick && (counter_r == 16'hFFFF);
		capEvFirst  = enable_r && (((capMode == `PGT_CPM_PIN) && pinRise) ||
			((capMode == `PGT_CPM_PEER) && peerRise));
		capEvSecond = enable_r && (((capMode == `PGT_CPM_PIN) && pinFall) ||
			((capMode == `PGT_CPM_PEER) && peerFall));
		swCap = wrEn && mapped && (paddr == `PGT_ADDR_MODE) &&
			!pwdata[`PGT_MOD_SWCAP_BIT] && enable_r;

		enable_nxt = enable_r;
		run_nxt = run_r;
		control_nxt = control_r;
		mode_nxt = mode_r;
		toggleEn_nxt = toggleEn_r;
		mask_nxt = mask_r;
		cmpFirst_nxt = cmpFirst_r;
		cmpSecond_nxt = cmpSecond_r;
		bufFirst_nxt = bufFirst_r;
		bufSecond_nxt = bufSecond_r;
		capFirst_nxt = capFirst_r;
		capSecond_nxt = capSecond_r;
		toggleFlop_nxt = toggleFlop_r;
		state_nxt = state_r;
		counter_nxt = counter_r;
		pready_nxt = (psel && penable && !pready_r);
		pslverr_nxt = (psel && penable && !pready_r) && !mapped;
		prdata_nxt = 32'h0000_0000;

		// the tick leaving the period value wraps to zero, so a period is second+1 counts
		if (countTick)
		begin
			counter_nxt = 16'(counter_r + 16'h0001);
			if (matchSecond && mode_r[`PGT_MOD_CLE_BIT])
				counter_nxt = 16'h0000;
		end

		if (matchSecond && control_r[`PGT_CTL_DBUF_BIT])
		begin
			cmpFirst_nxt  = bufFirst_r;
			cmpSecond_nxt = bufSecond_r;
		end

		// simultaneous events each invert once
		if (enable_r)
			toggleFlop_nxt = toggleFlop_r ^ (matchFirst && toggleEn_r[0])
				^ (matchSecond && toggleEn_r[1])
				^ ((capEvFirst || swCap) && toggleEn_r[2])
				^ (capEvSecond && toggleEn_r[3]);

		if (capEvFirst || swCap)
			capFirst_nxt = counter_r;
		if (capEvSecond)
			capSecond_nxt = counter_r;

		if (wrEn && mapped)
		begin
			unique case (paddr)
				`PGT_ADDR_ENABLE: enable_nxt = pwdata[0];
				`PGT_ADDR_RUN: run_nxt = pwdata[1:0];
				`PGT_ADDR_CONTROL: control_nxt = pwdata[2:0];
				`PGT_ADDR_MODE: mode_nxt = {1'b1, pwdata[6:0]};
				`PGT_ADDR_TOGGLE:
				begin
					toggleEn_nxt = pwdata[`PGT_TGL_EN_LSB +: 4];
					unique case (pwdata[`PGT_TGL_CTL_LSB +: 2])
						`PGT_TGL_INVERT: toggleFlop_nxt = !toggleFlop_r;
						`PGT_TGL_SET: toggleFlop_nxt = 1'b1;
						`PGT_TGL_CLEAR: toggleFlop_nxt = 1'b0;
						default: ;
					endcase
				end
				`PGT_ADDR_MASK: mask_nxt = pwdata[2:0];
				`PGT_ADDR_CMP_FIRST:
				begin
					bufFirst_nxt = pwdata[15:0];
					if (state_r == pgt_pkg::PGT_STOPPED || !control_r[`PGT_CTL_DBUF_BIT])
						cmpFirst_nxt = pwdata[15:0];
				end
				`PGT_ADDR_CMP_SECOND:
				begin
					bufSecond_nxt = pwdata[15:0];
					if (state_r == pgt_pkg::PGT_STOPPED || !control_r[`PGT_CTL_DBUF_BIT])
						cmpSecond_nxt = pwdata[15:0];
				end
				default: ;
			endcase
		end

		if (rdEn && mapped)
		begin
			unique case (paddr)
				`PGT_ADDR_ENABLE: prdata_nxt = {31'h0, enable_r};
				`PGT_ADDR_RUN: prdata_nxt = {30'h0, run_r};
				`PGT_ADDR_CONTROL: prdata_nxt = {29'h0, control_r};
				`PGT_ADDR_MODE: prdata_nxt = {24'h0, mode_r};
				`PGT_ADDR_TOGGLE: prdata_nxt = {26'h0, toggleFlop_r, 1'b0, toggleEn_r};
				`PGT_ADDR_STATUS: prdata_nxt = {29'h0, status_r};
				`PGT_ADDR_MASK: prdata_nxt = {29'h0, mask_r};
				`PGT_ADDR_CMP_FIRST: prdata_nxt = {16'h0, cmpFirst_r};
				`PGT_ADDR_CMP_SECOND: prdata_nxt = {16'h0, cmpSecond_r};
				`PGT_ADDR_CAP_FIRST: prdata_nxt = {16'h0, capFirst_r};
				`PGT_ADDR_CAP_SECOND: prdata_nxt = {16'h0, capSecond_r};
				default: prdata_nxt = {16'h0, counter_r};
			endcase
		end

		// run state: stop always wins, trigger start waits for pin rise
		if (!enable_r || run_nxt != `PGT_RUN_GO)
			state_nxt = pgt_pkg::PGT_STOPPED;
		else
			unique case (state_r)
				pgt_pkg::PGT_STOPPED: state_nxt = (control_r[`PGT_CTL_COUNT_START_SELECT_BIT] &&
					!control_r[`PGT_CTL_TRGEDGE_BIT]) ? pgt_pkg::PGT_ARMED :
					pgt_pkg::PGT_COUNTING;
				pgt_pkg::PGT_ARMED: if (pinRise) state_nxt = pgt_pkg::PGT_COUNTING;
				pgt_pkg::PGT_COUNTING: state_nxt = pgt_pkg::PGT_COUNTING;
			endcase
		if (state_nxt == pgt_pkg::PGT_STOPPED && state_r != pgt_pkg::PGT_STOPPED)
		begin
			counter_nxt = 16'h0000;
		end

		// sticky event status; a new event wins over the read-clear
		status_nxt = status_r;
		if (rdEn && mapped && paddr == `PGT_ADDR_STATUS)
			status_nxt = 3'h0;
		status_nxt = status_nxt | {overflow, matchSecond, matchFirst};
		matchInt_nxt = |({overflow, matchSecond, matchFirst} & ~mask_r);
		capFirstInt_nxt = capEvFirst || swCap;
		capSecondInt_nxt = capEvSecond;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			enable_r <= 1'b0; run_r <= 2'h0; control_r <= 3'h0;
			mode_r <= `PGT_RST_MODE; toggleEn_r <= 4'h0; mask_r <= `PGT_RST_MASK;
			status_r <= 3'h0; cmpFirst_r <= 16'h0000; cmpSecond_r <= 16'h0000;
			bufFirst_r <= 16'h0000; bufSecond_r <= 16'h0000;
			capFirst_r <= 16'h0000; capSecond_r <= 16'h0000;
			counter_r <= 16'h0000; toggleFlop_r <= 1'b0;
			pinPrev_r <= 1'b0; peerPrev_r <= 1'b0; state_r <= pgt_pkg::PGT_STOPPED;
			matchInt_r <= 1'b0; capFirstInt_r <= 1'b0; capSecondInt_r <= 1'b0;
			prdata_r <= 32'h0000_0000; pready_r <= 1'b0; pslverr_r <= 1'b0;
		end
		else
		begin
			enable_r <= enable_nxt; run_r <= run_nxt; control_r <= control_nxt;
			mode_r <= mode_nxt; toggleEn_r <= toggleEn_nxt; mask_r <= mask_nxt;
			status_r <= status_nxt; cmpFirst_r <= cmpFirst_nxt; cmpSecond_r <= cmpSecond_nxt;
			bufFirst_r <= bufFirst_nxt; bufSecond_r <= bufSecond_nxt;
			capFirst_r <= capFirst_nxt; capSecond_r <= capSecond_nxt;
			counter_r <= counter_nxt;
			toggleFlop_r <= toggleFlop_nxt;
			pinPrev_r <= timerInputPin; peerPrev_r <= peerToggleFlop; state_r <= state_nxt;
			matchInt_r <= matchInt_nxt; capFirstInt_r <= capFirstInt_nxt;
			capSecondInt_r <= capSecondInt_nxt;
			prdata_r <= prdata_nxt; pready_r <= pready_nxt; pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign timerOutputPin = toggleFlop_r;
	assign matchInterrupt = matchInt_r;
	assign captureFirstInterrupt = capFirstInt_r;
	assign captureSecondInterrupt = capSecondInt_r;

	a_second_match_irq: assert property (@(posedge clk) disable iff (sys_rst)
		(matchSecond && !mask_r[1]) |=> matchInterrupt)
		else $error("second match did not raise the match interrupt");
	a_mask_all: assert property (@(posedge clk) disable iff (sys_rst)
		(mask_r == 3'h7 && $past(mask_r) == 3'h7) |-> !matchInterrupt)
		else $error("match interrupt raised while fully masked");
	a_cap_second_irq: assert property (@(posedge clk) disable iff (sys_rst)
		capEvSecond |=> (captureSecondInterrupt && capSecond_r == $past(counter_r)))
		else $error("second capture missing value or interrupt");
	a_pin_capture: assert property (@(posedge clk) disable iff (sys_rst)
		(enable_r && capMode == `PGT_CPM_PIN && pinRise) |=> captureFirstInterrupt)
		else $error("pin rise did not capture into first");
	a_capture_off: assert property (@(posedge clk) disable iff (sys_rst)
		(capMode == `PGT_CPM_OFF) |-> !capEvFirst && !capEvSecond)
		else $error("capture while capture mode is off");
	a_dbuf_load: assert property (@(posedge clk) disable iff (sys_rst)
		(matchSecond && control_r[0] && !wrEn) |=> cmpSecond_r == $past(bufSecond_r))
		else $error("double buffer did not load on second match");
	a_disabled_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!enable_r |=> $stable(counter_r) || counter_r == 16'h0000)
		else $error("counter moved while channel disabled");
	a_armed_wait: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == pgt_pkg::PGT_ARMED) |-> !countTick ##1 $stable(counter_r))
		else $error("counter ran before trigger edge");
	a_force_low: assert property (@(posedge clk) disable iff (sys_rst)
		(wrEn && mapped && paddr == `PGT_ADDR_TOGGLE && pwdata[5:4] == 2'h2)
		|=> !timerOutputPin)
		else $error("toggle flop not forced low");
	a_flop_set: assert property (@(posedge clk) disable iff (sys_rst)
		(wrEn && mapped && paddr == `PGT_ADDR_TOGGLE && pwdata[5:4] == 2'h1)
		|=> timerOutputPin)
		else $error("toggle flop not set high");
	a_period_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(matchSecond && mode_r[`PGT_MOD_CLE_BIT]) |=> counter_r == 16'h0000)
		else $error("counter did not wrap after the period match");
	a_run_stop: assert property (@(posedge clk) disable iff (sys_rst)
		(run_r != `PGT_RUN_GO) |-> state_r == pgt_pkg::PGT_STOPPED && counter_r == 16'h0000)
		else $error("counter active while run control is off");
	a_sw_capture: assert property (@(posedge clk) disable iff (sys_rst)
		swCap |=> capFirst_r == $past(counter_r))
		else $error("software capture did not latch the counter");
endmodule // pgt_timer

// [pgt_pin_model.sv]
// partner model: pulses on the timer input pin or on the peer channel flop
`timescale 1ns/1ps
module pgt_pin_model
(
	input  wire logic       clk,
	input  wire logic       sysRst,
	input  wire logic       req,
	input  wire logic       toPeer,
	input  wire logic [7:0] width,
	output logic            pinLevel,
	output logic            peerLevel,
	output logic            busy
);
	logic [7:0] left_r;
	logic       peer_r;
	always_ff @(posedge clk or posedge sysRst)
	begin
		if (sysRst)
		begin
			left_r <= 8'h00;
			peer_r <= 1'b0;
		end
		else if (req)
		begin
			left_r <= width;
			peer_r <= toPeer;
		end
		else if (left_r != 8'h00)
		begin
			left_r <= left_r - 8'h01;
		end
	end
	// both lines idle low between pulses, so every pulse gives one rise and one fall
	assign busy      = left_r != 8'h00;
	assign pinLevel  = busy && !peer_r;
	assign peerLevel = busy && peer_r;
endmodule // pgt_pin_model

// [pgt_timer_tb.sv]
// bench for the timer channel: register access, pulse output, one-shot, capture
`timescale 1ns/1ps
`include "pgt_cfg.svh"
module pgt_timer_tb;
	logic        clk = 1'b0;
	logic        sysRst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, pin, peer, outPin, irq, capIrqA, capIrqB, busy;
	logic        req = 1'b0;
	logic        toPeer = 1'b0;
	logic [7:0]  width = 8'h00;
	logic        outPrev = 1'b0;
	logic [33:0] notes[$];
	logic [33:0] note;
	logic [31:0] seed = 32'h0000_0049;
	logic [31:0] v;
	logic [7:0]  w;
	int          failures = 0, compares = 0, cyc = 0, edges = 0, irqs = 0, e0 = 0;
	int          capA = 0, capB = 0, riseAt = 0, period = 0, highW = 0;
	int          irqMark = 0, irqPer = 0, a0 = 0, b0 = 0, n = 0;
	always #10 clk = ~clk;
	pgt_timer DUT
	(
		.clk                    (clk),
		.sys_rst                (sysRst),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.timerInputPin          (pin),
		.peerToggleFlop         (peer),
		.timerOutputPin         (outPin),
		.matchInterrupt         (irq),
		.captureFirstInterrupt  (capIrqA),
		.captureSecondInterrupt (capIrqB)
	);
	pgt_pin_model partner
	(
		.clk       (clk),
		.sysRst    (sysRst),
		.req       (req),
		.toPeer    (toPeer),
		.width     (width),
		.pinLevel  (pin),
		.peerLevel (peer),
		.busy      (busy)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic bound(input string what);
		if (n >= 200)
		begin
			check(what, 32'h0000_0000, 32'h0000_0001);
			tally_and_finish();
		end
	endtask
	task automatic gap(input int k);
		repeat (k) @(posedge clk);
	endtask
	// the note is queued first so the watcher can pair it with the answer in order
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] nt);
		notes.push_back(nt);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 200);
		bound("bus answer");
		v = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0_0000_0000);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, {2'b10, exp});
	endtask
	task automatic pulse(input logic p, input logic [7:0] len);
		@(posedge clk);
		req    <= 1'b1;
		toPeer <= p;
		width  <= len;
		@(posedge clk);
		req <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 200);
		bound("pulse end");
		gap(4);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		outPrev <= outPin;
		if (irq === 1'b1)
			irqs++;
		if (capIrqA === 1'b1)
			capA++;
		if (capIrqB === 1'b1)
			capB++;
		if (outPin !== outPrev)
			edges++;
		if (outPin === 1'b1 && outPrev === 1'b0)
		begin
			period = cyc - riseAt;
			riseAt = cyc;
			irqPer = irqs - irqMark;
			irqMark = irqs;
		end
		if (outPin === 1'b0 && outPrev === 1'b1)
			highW = cyc - riseAt;
		if (pready === 1'b1)
		begin
			note = notes.pop_front();
			check("slave error", {31'h0000_0000, pslverr}, {31'h0000_0000, note[32]});
			if (note[33])
				check("read data", prdata, note[31:0]);
		end
	end
	initial
	begin
		gap(4);
		sysRst <= 1'b0;
		rd(`PGT_ADDR_MASK, 32'h0000_0007);
		rd(`PGT_ADDR_MODE, 32'h0000_0080);
		apb(1'b0, 12'h030, 32'h0000_0000, {2'b11, 32'h0000_0000});
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0010);
		gap(3);
		check("flop set", outPin, 32'h0000_0001);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0000);
		gap(3);
		check("flop invert", outPin, 32'h0000_0000);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0010);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0020);
		gap(3);
		check("flop clear", outPin, 32'h0000_0000);
		wr(`PGT_ADDR_ENABLE, 32'h0000_0001);
		wr(`PGT_ADDR_MODE, 32'h0000_0089);
		wr(`PGT_ADDR_CONTROL, 32'h0000_0001);
		wr(`PGT_ADDR_CMP_FIRST, 32'h0000_0003);
		wr(`PGT_ADDR_CMP_SECOND, 32'h0000_0007);
		rd(`PGT_ADDR_CMP_FIRST, 32'h0000_0003);
		rd(`PGT_ADDR_CMP_SECOND, 32'h0000_0007);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0023);
		wr(`PGT_ADDR_MASK, 32'h0000_0005);
		wr(`PGT_ADDR_RUN, 32'h0000_0003);
		gap(40);
		check("period", period, 32'h0000_0008);
		check("high time", highW, 32'h0000_0004);
		check("irq per period", irqPer, 32'h0000_0001);
		wr(`PGT_ADDR_CMP_FIRST, 32'h0000_0001);
		wr(`PGT_ADDR_CMP_SECOND, 32'h0000_000B);
		gap(60);
		check("buffered period", period, 32'h0000_000C);
		check("buffered high", highW, 32'h0000_000A);
		wr(`PGT_ADDR_MASK, 32'h0000_0000);
		gap(40);
		check("unmasked irq", irqPer, 32'h0000_0002);
		wr(`PGT_ADDR_RUN, 32'h0000_0000);
		gap(2);
		e0 = edges;
		gap(30);
		rd(`PGT_ADDR_COUNTER, 32'h0000_0000);
		check("stopped edges", edges - e0, 32'h0000_0000);
		wr(`PGT_ADDR_CONTROL, 32'h0000_0000);
		wr(`PGT_ADDR_MODE, 32'h0000_0081);
		e0 = edges;
		wr(`PGT_ADDR_RUN, 32'h0000_0003);
		gap(40);
		check("free run edges", edges - e0, 32'h0000_0002);
		wr(`PGT_ADDR_RUN, 32'h0000_0000);
		wr(`PGT_ADDR_MODE, 32'h0000_0080);
		wr(`PGT_ADDR_RUN, 32'h0000_0003);
		repeat (5) pulse(1'b0, 8'h03);
		rd(`PGT_ADDR_COUNTER, 32'h0000_0005);
		for (int k = 0; k < 2; k++)
		begin
			wr(`PGT_ADDR_MODE, k ? 32'h0000_00B1 : 32'h0000_00A1);
			wr(`PGT_ADDR_TOGGLE, 32'h0000_003C);
			v = rnd();
			w = 8'h03 + {5'h00, v[2:0]};
			{a0, b0, e0} = {capA, capB, edges};
			pulse(k[0], w);
			apb(1'b0, `PGT_ADDR_CAP_FIRST, 32'h0000_0000, 34'h0_0000_0000);
			rd(`PGT_ADDR_CAP_SECOND, v + {24'h00_0000, w});
			check("first capture irq", capA - a0, 32'h0000_0001);
			check("second capture irq", capB - b0, 32'h0000_0001);
			check("capture toggles", edges - e0, 32'h0000_0002);
		end
		wr(`PGT_ADDR_MODE, 32'h0000_0081);
		a0 = capA;
		pulse(1'b0, 8'h04);
		check("capture off", capA - a0, 32'h0000_0000);
		wr(`PGT_ADDR_RUN, 32'h0000_0000);
		wr(`PGT_ADDR_MODE, 32'h0000_0001);
		rd(`PGT_ADDR_CAP_FIRST, 32'h0000_0000);
		wr(`PGT_ADDR_CONTROL, 32'h0000_0002);
		wr(`PGT_ADDR_CMP_FIRST, 32'h0000_0006);
		wr(`PGT_ADDR_CMP_SECOND, 32'h0000_000A);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0023);
		wr(`PGT_ADDR_MASK, 32'h0000_0005);
		wr(`PGT_ADDR_MODE, 32'h0000_0089);
		wr(`PGT_ADDR_RUN, 32'h0000_0003);
		gap(20);
		rd(`PGT_ADDR_COUNTER, 32'h0000_0000);
		pulse(1'b0, 8'h03);
		n = 0;
		while (irq !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		bound("one-shot end");
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0030);
		e0 = edges;
		gap(30);
		check("pulse width", highW, 32'h0000_0004);
		check("after one-shot", edges - e0, 32'h0000_0000);
		wr(`PGT_ADDR_RUN, 32'h0000_0000);
		wr(`PGT_ADDR_ENABLE, 32'h0000_0000);
		wr(`PGT_ADDR_TOGGLE, 32'h0000_0033);
		wr(`PGT_ADDR_RUN, 32'h0000_0003);
		e0 = edges;
		gap(30);
		rd(`PGT_ADDR_COUNTER, 32'h0000_0000);
		check("disabled edges", edges - e0, 32'h0000_0000);
		tally_and_finish();
	end
endmodule // pgt_timer_tb
